/* File: src/buck_sequencer.sv */
// start-up, shutdown and overcurrent response sequencer of a buck regulator
// assumes a bus engine presenting byte writes/reads; analog comparators async
module buck_sequencer
  import seq_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       core_supply_good_i,
  input  wire logic       enable_pin_i,
  input  wire logic       valley_over_limit_i,
  input  wire logic       undervoltage_cmp_i,
  input  wire logic       ref_above_fb_i,
  input  wire logic       ls_current_valid_i,
  input  wire logic [9:0] ls_current_i,
  input  wire logic       second_mode_select_strap_i,
  input  wire logic [1:0] strap_freq_i,
  input  wire logic       bus_wr_i,
  input  wire logic       bus_rd_i,
  input  wire logic [7:0] bus_addr_i,
  input  wire logic [7:0] bus_wdata_i,
  input  wire logic       bus_hi_byte_i,
  output logic      [7:0] bus_rdata_o,
  output logic            bus_ready_o,
  output logic            hs_enable_o,
  output logic            ls_enable_o,
  output logic            stage_tristate_o,
  output logic            continuous_mode_o,
  output logic      [1:0] freq_sel_o,
  output logic      [9:0] vref_code_o,
  output logic            init_done_o,
  output logic      [3:0] state_o
);
  typedef struct packed {
    seq_state_t  st;
    logic [2:0]  en_sync;
    logic [2:0]  uv_sync;
    logic [2:0]  vlim_sync;
    logic [2:0]  ref_sync;
    logic [2:0]  pg_sync;
    logic [4:0]  deg_cnt;
    logic        en_flt;
    logic        en_prev;
    logic [14:0] cyc_cnt;
    logic [6:0]  us_cnt;
    logic [15:0] us_tick;
    logic [15:0] uv_cnt;
    logic [19:0] ramp_acc;
    logic [9:0]  vref;
    logic        first_hs;
    logic [7:0]  run_cmd;
    logic [7:0]  onoff;
    logic [15:0] ton;
    logic [15:0] ss;
    logic [15:0] toff;
    logic [15:0] stop;
    logic [15:0] vout_cmd;
    logic [15:0] slew;
    logic [7:0]  uv_resp;
    logic [7:0]  freq;
    logic [7:0]  usercfg;
    logic [7:0]  istat;
    logic [19:0] isum;
    logic [9:0]  iavg;
    logic [9:0]  icnt;
    logic        ls_prev;
    logic [7:0]  rdata;
    logic        ready;
    logic        hs;
    logic        ls;
    logic        tri_st;
    logic        init_done;
  } seq_regs_t;

  seq_regs_t cur_r;
  seq_regs_t cur_nxt;

  logic        en_level;
  logic        on_req;
  logic        uv_q;
  logic        vlim_q;
  logic        ref_q;
  logic [15:0] ton_us;
  logic [15:0] ss_us;
  logic [15:0] stop_us;
  logic [9:0]  target;
  logic [19:0] step;
  logic        us_pulse;

  always_comb begin
    // turn-on delay clamp in microseconds
    ton_us = cur_r.ton;
    if (ton_us < 16'(TON_MIN_US)) begin
      ton_us = 16'(TON_MIN_US);
    end else if (ton_us > 16'(TON_MAX_US)) begin
      ton_us = 16'(TON_MAX_US);
    end
    ss_us   = 16'(SS_BASE_US) << (cur_r.ss[2:0] > 3'd4 ? 3'd4 : cur_r.ss[2:0]);
    stop_us = 16'(STOP_BASE_US) << cur_r.stop[1:0];
    target  = (cur_r.vout_cmd[9:0] != 10'h000) ? cur_r.vout_cmd[9:0] : BOOT_CODE_DEF;
  end

  always_comb begin
    cur_nxt  = cur_r;
    us_pulse = (cur_r.us_cnt == 7'(US_CYC - 1));
    step     = 20'h00000;
    // three-stage synchronizers, second and third must agree
    cur_nxt.en_sync  = {cur_r.en_sync[1:0], enable_pin_i};
    cur_nxt.uv_sync  = {cur_r.uv_sync[1:0], undervoltage_cmp_i};
    cur_nxt.vlim_sync = {cur_r.vlim_sync[1:0], valley_over_limit_i};
    cur_nxt.ref_sync = {cur_r.ref_sync[1:0], ref_above_fb_i};
    cur_nxt.pg_sync  = {cur_r.pg_sync[1:0], core_supply_good_i};
    uv_q  = (cur_r.uv_sync[2] == cur_r.uv_sync[1]) ? cur_r.uv_sync[2] : 1'b0;
    vlim_q = (cur_r.vlim_sync[2] == cur_r.vlim_sync[1]) ? cur_r.vlim_sync[2] : 1'b0;
    ref_q = (cur_r.ref_sync[2] == cur_r.ref_sync[1]) ? cur_r.ref_sync[2] : cur_r.first_hs;
    // enable deglitch
    if (cur_r.en_sync[2] == cur_r.en_sync[1] && cur_r.en_sync[2] != cur_r.en_flt) begin
      // level must hold the full deglitch span before it counts
      if (cur_r.deg_cnt == 5'(DEGLITCH_CYC - 1)) begin
        cur_nxt.en_flt  = cur_r.en_sync[2];
        cur_nxt.deg_cnt = 5'd0;
      end else begin
        cur_nxt.deg_cnt = cur_r.deg_cnt + 5'd1;
      end
    end else begin
      cur_nxt.deg_cnt = 5'd0;
    end
    cur_nxt.en_prev = cur_r.en_flt;
    en_level = cur_r.en_flt;
    on_req   = (!cur_r.onoff[ONOFF_PIN_BIT] || en_level) &&
               (!cur_r.onoff[ONOFF_CMD_BIT] || cur_r.run_cmd[RUN_ON_BIT]);
    // microsecond timebase
    cur_nxt.us_cnt = us_pulse ? 7'd0 : cur_r.us_cnt + 7'd1;
    if (us_pulse) begin
      cur_nxt.us_tick = cur_r.us_tick + 16'd1;
    end
    // bus port, gated until init completes
    cur_nxt.ready = 1'b0;
    cur_nxt.rdata = 8'h00;
    if (cur_r.st != ST_OFF && cur_r.st != ST_INIT && (bus_wr_i || bus_rd_i)) begin
      cur_nxt.ready = 1'b1;
      if (bus_wr_i) begin
        unique case (bus_addr_i)
          ADDR_RUN:      cur_nxt.run_cmd = bus_wdata_i;
          ADDR_ONOFF:    cur_nxt.onoff   = bus_wdata_i;
          ADDR_UV_RESP:  cur_nxt.uv_resp = bus_wdata_i;
          ADDR_FREQ:     cur_nxt.freq    = bus_wdata_i;
          ADDR_USERCFG:  cur_nxt.usercfg = bus_wdata_i;
          ADDR_CUR_STAT: cur_nxt.istat   = cur_r.istat & ~bus_wdata_i;
          ADDR_TON_DLY: begin
            if (bus_hi_byte_i) cur_nxt.ton[15:8] = bus_wdata_i;
            else cur_nxt.ton[7:0] = bus_wdata_i;
          end
          ADDR_SS_TIME: begin
            if (bus_hi_byte_i) cur_nxt.ss[15:8] = bus_wdata_i;
            else cur_nxt.ss[7:0] = bus_wdata_i;
          end
          ADDR_TOFF_DLY: begin
            if (bus_hi_byte_i) cur_nxt.toff[15:8] = bus_wdata_i;
            else cur_nxt.toff[7:0] = bus_wdata_i;
          end
          ADDR_STOP_TIM: begin
            if (bus_hi_byte_i) cur_nxt.stop[15:8] = bus_wdata_i;
            else cur_nxt.stop[7:0] = bus_wdata_i;
          end
          ADDR_VOUT_CMD: begin
            if (bus_hi_byte_i) cur_nxt.vout_cmd[15:8] = bus_wdata_i;
            else cur_nxt.vout_cmd[7:0] = bus_wdata_i;
          end
          ADDR_SLEW: begin
            if (bus_hi_byte_i) cur_nxt.slew[15:8] = bus_wdata_i;
            else cur_nxt.slew[7:0] = bus_wdata_i;
          end
          default: cur_nxt.ready = 1'b1;
        endcase
      end else begin
        unique case (bus_addr_i)
          ADDR_RUN:      cur_nxt.rdata = cur_r.run_cmd;
          ADDR_ONOFF:    cur_nxt.rdata = cur_r.onoff;
          ADDR_UV_RESP:  cur_nxt.rdata = cur_r.uv_resp;
          ADDR_FREQ:     cur_nxt.rdata = cur_r.freq;
          ADDR_USERCFG:  cur_nxt.rdata = cur_r.usercfg;
          ADDR_CUR_STAT: cur_nxt.rdata = cur_r.istat;
          ADDR_CUR_TEL:  cur_nxt.rdata = bus_hi_byte_i ? {6'h00, cur_r.iavg[9:8]}
                                                       : cur_r.iavg[7:0];
          ADDR_TON_DLY:  cur_nxt.rdata = bus_hi_byte_i ? cur_r.ton[15:8] : cur_r.ton[7:0];
          ADDR_SS_TIME:  cur_nxt.rdata = bus_hi_byte_i ? cur_r.ss[15:8] : cur_r.ss[7:0];
          ADDR_TOFF_DLY: cur_nxt.rdata = bus_hi_byte_i ? cur_r.toff[15:8] : cur_r.toff[7:0];
          ADDR_STOP_TIM: cur_nxt.rdata = bus_hi_byte_i ? cur_r.stop[15:8] : cur_r.stop[7:0];
          ADDR_VOUT_CMD: cur_nxt.rdata = bus_hi_byte_i ? cur_r.vout_cmd[15:8]
                                                       : cur_r.vout_cmd[7:0];
          ADDR_SLEW:     cur_nxt.rdata = bus_hi_byte_i ? cur_r.slew[15:8] : cur_r.slew[7:0];
          default:       cur_nxt.rdata = 8'h00;
        endcase
      end
    end
    // valley clamp: low-side held, high-side pushed out
    // flag set wins over a clear in the same cycle
    if (vlim_q && !cur_r.tri_st) begin
      cur_nxt.istat[VALLEY_FLAG_BIT] = 1'b1;
    end
    // average low-side current over each low-side on-time
    // long on-times average their first 1023 samples, sum stays in 20 bits
    if (cur_r.ls && ls_current_valid_i && cur_r.icnt != 10'h3FF) begin
      cur_nxt.isum = cur_r.isum + {10'h000, ls_current_i};
      cur_nxt.icnt = cur_r.icnt + 10'd1;
    end
    if (cur_r.ls_prev && !cur_r.ls) begin
      cur_nxt.iavg = (cur_r.icnt != 10'd0) ? 10'(cur_r.isum / cur_r.icnt)
                                           : cur_r.iavg;
      cur_nxt.isum = 20'h00000;
      cur_nxt.icnt = 10'd0;
    end
    cur_nxt.ls_prev = cur_r.ls;
    // sequencer
    unique case (cur_r.st)
      ST_OFF: begin
        cur_nxt.cyc_cnt = 15'd0;
        if (cur_r.pg_sync[2] && cur_r.pg_sync[1]) begin
          cur_nxt.st = ST_INIT;
        end
      end
      ST_INIT: begin
        cur_nxt.cyc_cnt = cur_r.cyc_cnt + 15'd1;
        if (cur_r.cyc_cnt == 15'(INIT_CYC - 1)) begin
          cur_nxt.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        cur_nxt.vref = 10'h000;
        if (on_req && (!cur_r.onoff[ONOFF_PIN_BIT] || !cur_r.en_prev || en_level)) begin
          cur_nxt.st      = ST_TON;
          cur_nxt.us_tick = 16'd0;
        end
      end
      ST_TON: begin
        if (!on_req) begin
          cur_nxt.st = ST_TOFF;
          cur_nxt.us_tick = 16'd0;
        end else if (cur_r.us_tick >= ton_us) begin
          cur_nxt.st       = ST_SS;
          cur_nxt.us_tick  = 16'd0;
          cur_nxt.ramp_acc = 20'h00000;
          cur_nxt.first_hs = 1'b0;
        end
      end
      ST_SS: begin
        step = 20'({target, 10'h000} / {4'h0, ss_us});
        if (us_pulse) begin
          cur_nxt.ramp_acc = cur_r.ramp_acc + step;
        end
        cur_nxt.vref = cur_r.ramp_acc[19:10];
        if (ref_q) begin
          cur_nxt.first_hs = 1'b1;
        end
        if (!on_req) begin
          cur_nxt.st = ST_TOFF;
          cur_nxt.us_tick = 16'd0;
        end else if (cur_r.ramp_acc[19:10] >= target) begin
          cur_nxt.st   = ST_RUN;
          cur_nxt.vref = target;
        end
      end
      ST_RUN: begin
        // slew toward new setpoint, slew register in codes per microsecond
        if (us_pulse && cur_r.vref < target) begin
          cur_nxt.vref = (target - cur_r.vref > cur_r.slew[9:0]) ?
                         cur_r.vref + cur_r.slew[9:0] : target;
        end else if (us_pulse && cur_r.vref > target) begin
          cur_nxt.vref = (cur_r.vref - target > cur_r.slew[9:0]) ?
                         cur_r.vref - cur_r.slew[9:0] : target;
        end
        if (uv_q) begin
          if (us_pulse) cur_nxt.uv_cnt = cur_r.uv_cnt + 16'd1;
        end else begin
          cur_nxt.uv_cnt = 16'd0;
        end
        if (!on_req) begin
          cur_nxt.st = ST_TOFF;
          cur_nxt.us_tick = 16'd0;
        end else if (uv_q && cur_r.uv_cnt >= {8'h00, cur_r.uv_resp[2:0], 5'h00}) begin
          // current limit never stops us; only the qualified undervoltage does
          cur_nxt.uv_cnt  = 16'd0;
          cur_nxt.us_tick = 16'd0;
          cur_nxt.st = cur_r.uv_resp[UV_RESTART_BIT] ? ST_HICCUP : ST_LATCH;
        end
      end
      ST_TOFF: begin
        if (cur_r.us_tick >= cur_r.toff) begin
          cur_nxt.st       = ST_STOP;
          cur_nxt.us_tick  = 16'd0;
          cur_nxt.ramp_acc = {cur_r.vref, 10'h000};
        end
      end
      ST_STOP: begin
        // slope from boot level, not present output
        step = 20'({BOOT_CODE_DEF, 10'h000} / {4'h0, stop_us});
        if (us_pulse) begin
          cur_nxt.ramp_acc = (cur_r.ramp_acc > step) ? cur_r.ramp_acc - step : 20'h00000;
        end
        cur_nxt.vref = cur_r.ramp_acc[19:10];
        if (cur_r.ramp_acc[19:10] <= STOP_LEVEL_CODE) begin
          cur_nxt.st   = ST_IDLE;
          cur_nxt.vref = 10'h000;
        end
      end
      ST_HICCUP: begin
        if (cur_r.us_tick >= 16'(HICCUP_US)) begin
          cur_nxt.st      = ST_TON;
          cur_nxt.us_tick = 16'd0;
        end
      end
      ST_LATCH: begin
        if (cur_r.onoff[ONOFF_PIN_BIT] && !en_level) begin
          cur_nxt.st = ST_IDLE;
        end
      end
      default: cur_nxt.st = ST_OFF;
    endcase
    if (!(cur_r.pg_sync[2] && cur_r.pg_sync[1]) && cur_r.pg_sync[2] == cur_r.pg_sync[1]) begin
      cur_nxt.st = ST_OFF;
    end
    // timed states start on a whole microsecond
    if (cur_nxt.st != cur_r.st) begin
      cur_nxt.us_cnt = 7'd0;
    end
    cur_nxt.init_done = (cur_nxt.st != ST_OFF && cur_nxt.st != ST_INIT);
    // power stage drive
    cur_nxt.hs     = 1'b0;
    cur_nxt.ls     = 1'b0;
    cur_nxt.tri_st = 1'b1;
    if (cur_nxt.st == ST_SS || cur_nxt.st == ST_RUN || cur_nxt.st == ST_TOFF ||
        cur_nxt.st == ST_STOP) begin
      cur_nxt.tri_st = 1'b0;
      cur_nxt.hs = (cur_nxt.st != ST_SS || ref_q) && !vlim_q;
      cur_nxt.ls = (cur_nxt.st != ST_SS || cur_nxt.first_hs);
      if (vlim_q) cur_nxt.ls = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cur_r          <= '0;
      cur_r.st       <= ST_OFF;
      cur_r.run_cmd  <= RUN_RST;
      cur_r.onoff    <= ONOFF_RST;
      cur_r.ton      <= TON_RST;
      cur_r.ss       <= SS_RST;
      cur_r.toff     <= TOFF_RST;
      cur_r.stop     <= STOP_RST;
      cur_r.slew     <= SLEW_RST;
      cur_r.uv_resp  <= UV_RESP_RST;
      cur_r.freq     <= FREQ_RST;
      cur_r.usercfg  <= USERCFG_RST;
      cur_r.tri_st   <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      continuous_mode_o <= 1'b0;
      freq_sel_o        <= 2'b00;
    end else begin
      continuous_mode_o <= cur_r.usercfg[CONT_MODE_BIT];
      freq_sel_o        <= cur_r.freq[FREQ_CMD_BIT] ? cur_r.freq[1:0]
                         : (second_mode_select_strap_i ? strap_freq_i : 2'b00);
    end
  end

  assign bus_rdata_o      = cur_r.rdata;
  assign bus_ready_o      = cur_r.ready;
  assign hs_enable_o      = cur_r.hs;
  assign ls_enable_o      = cur_r.ls;
  assign stage_tristate_o = cur_r.tri_st;
  assign vref_code_o      = cur_r.vref;
  assign init_done_o      = cur_r.init_done;
  assign state_o          = cur_r.st;
endmodule

/* File: src/seq_pkg.sv */
// constants, register map and state encoding for the buck start/stop sequencer
// assumes a 100 MHz system clock and a byte-wide command port from the bus engine
// Notes on behaviour
// - initialization starts whenever core supply is good, regardless of enable pin
// - initialization lasts about 200 microseconds
// - bus reads and writes accepted only after initialization completes
// - after initialization, enable rising moves sequencer into turn-on delay; code enters it on a high enable level, no rising edge needed
// - turn-on delay from command, limited to 0.05 ms up to 2 ms
// - soft-start ramp follows delay, 1, 2, 4, 8 or 16 ms selectable
// - without prebias ramp target climbs from zero to boot or commanded voltage
// - prebiased start keeps low-side off until first high-side pulse
// - high-side pulses begin once rising reference exceeds divided feedback
// - soft-stop time selectable 0.5, 1, 2 or 4 ms
// - after stop and turn-off delay, keep switching while reference ramps down
// - at 200 mV during soft-stop, stop switching and tri-state the stage
// - soft-stop slope from boot voltage and stop time, not present output
// - setpoint changes slewed at the configured transition rate
// - frequency from strap or command; continuous mode from its own bit
// - low-side stays on while valley current exceeds limit
// - valley clamping sets the valley limit flag in current status
// - current limit never shuts down; undervoltage fault does after its delay
// - restart bit clear: latch drivers off until supply reset or enable toggle
// - restart bit set: hiccup 56 ms then restart, unlimited retries
// - undervoltage detection disabled during soft-start, enabled after it
// - current telemetry is average low-side current over each low-side on-time
// - enable input deglitched; pulses under 0.2 microseconds ignored
// - undervoltage recovery during delay resets the delay timer to zero
package seq_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned INIT_TIME_US     = 200;
  localparam int unsigned INIT_CYC         = INIT_TIME_US * CLK_MHZ;
  localparam int unsigned DEGLITCH_NS      = 200;
  localparam int unsigned DEGLITCH_CYC     = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned US_CYC           = CLK_MHZ;
  localparam int unsigned HICCUP_MS        = 56;
  localparam int unsigned HICCUP_US        = HICCUP_MS * 1000;
  localparam int unsigned TON_MIN_US       = 50;
  localparam int unsigned TON_MAX_US       = 2000;
  localparam int unsigned SS_BASE_US       = 1000;
  localparam int unsigned STOP_BASE_US     = 500;
  localparam int unsigned UV_DELAY_UNIT_US = 1;
  localparam logic [9:0]  STOP_LEVEL_CODE  = 10'h066;  // 200 mV at 1.953 mV steps
  localparam logic [9:0]  BOOT_CODE_DEF    = 10'h0CD;  // reset boot target
  localparam logic [7:0] ADDR_RUN      = 8'h01;
  localparam logic [7:0] ADDR_ONOFF    = 8'h02;
  localparam logic [7:0] ADDR_TON_DLY  = 8'h60;
  localparam logic [7:0] ADDR_SS_TIME  = 8'h61;
  localparam logic [7:0] ADDR_TOFF_DLY = 8'h64;
  localparam logic [7:0] ADDR_STOP_TIM = 8'h65;
  localparam logic [7:0] ADDR_VOUT_CMD = 8'h21;
  localparam logic [7:0] ADDR_SLEW     = 8'h27;
  localparam logic [7:0] ADDR_UV_RESP  = 8'h45;
  localparam logic [7:0] ADDR_FREQ     = 8'h33;
  localparam logic [7:0] ADDR_USERCFG  = 8'hD0;
  localparam logic [7:0] ADDR_CUR_STAT = 8'h7B;
  localparam logic [7:0] ADDR_CUR_TEL  = 8'h8C;
  localparam logic [7:0]  RUN_RST      = 8'h80;
  localparam logic [7:0]  ONOFF_RST    = 8'h17;
  localparam logic [15:0] TON_RST      = 16'h0032;
  localparam logic [15:0] SS_RST       = 16'h0001;
  localparam logic [15:0] TOFF_RST     = 16'h0000;
  localparam logic [15:0] STOP_RST     = 16'h0001;
  localparam logic [15:0] SLEW_RST     = 16'h0001;
  localparam logic [7:0]  UV_RESP_RST  = 8'h08;
  localparam logic [7:0]  FREQ_RST     = 8'h00;
  localparam logic [7:0]  USERCFG_RST  = 8'h00;
  localparam int unsigned RUN_ON_BIT      = 7;
  localparam int unsigned ONOFF_PIN_BIT   = 2;
  localparam int unsigned ONOFF_CMD_BIT   = 3;
  localparam int unsigned UV_RESTART_BIT  = 3;
  localparam int unsigned CONT_MODE_BIT   = 0;
  localparam int unsigned FREQ_CMD_BIT    = 7;
  localparam int unsigned VALLEY_FLAG_BIT = 6;
  typedef enum logic [3:0] {
    ST_OFF     = 4'b0000,
    ST_INIT    = 4'b0001,
    ST_IDLE    = 4'b0011,
    ST_TON     = 4'b0010,
    ST_SS      = 4'b0110,
    ST_RUN     = 4'b0111,
    ST_TOFF    = 4'b0101,
    ST_STOP    = 4'b0100,
    ST_HICCUP  = 4'b1100,
    ST_LATCH   = 4'b1101
  } seq_state_t;
endpackage

/* File: sim/pmbus_host_model.sv */
// host side model: byte command port master and enable pin driver
// assumes requests are one-cycle pulses answered on the taking edge, ready sampled just after it
module pmbus_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       ready_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            hi_o,
  output logic            en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
    hi_o = 1'b0;
    en_o = 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic h, input logic [7:0] d,
                      output logic rdy, output logic [7:0] q);
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    hi_o <= h;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // released lines do not keep the last value
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
    rdy = ready_i;
    q = rdata_i;
  endtask
  task automatic drive_en(input logic v);
    @(posedge clk_i);
    en_o <= v;
  endtask
endmodule

/* File: sim/buck_sequencer_properties.sv */
// checker on the sequencer ports: bus answer, init and delay lengths, stop path
// assumes state_o carries the package state encoding
module buck_sequencer_checker
  import seq_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic       bus_wr_i,
  input wire logic       bus_rd_i,
  input wire logic       bus_ready_o,
  input wire logic       stage_tristate_o,
  input wire logic       init_done_o,
  input wire logic [3:0] state_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic [31:0] init_cnt_r;
  logic [31:0] ton_cnt_r;
  always_ff @(posedge clk_sys_i) begin
    init_cnt_r <= (state_o == ST_INIT) ? init_cnt_r + 32'h1 : 32'h0;
    ton_cnt_r  <= (state_o == ST_TON) ? ton_cnt_r + 32'h1 : 32'h0;
  end
  chk_early_refused: assert property (!init_done_o && (bus_wr_i || bus_rd_i) |=> !bus_ready_o)
    else $error("ready answered before init done");
  chk_ready_answer: assert property (init_done_o && (bus_wr_i || bus_rd_i) |=> bus_ready_o)
    else $error("request after init not answered");
  chk_init_length: assert property ($fell(state_o == ST_INIT) && state_o != ST_OFF
    |-> init_cnt_r inside {[INIT_CYC - 4 : INIT_CYC + 4]}) else $error("init length wrong");
  chk_ton_range: assert property ($fell(state_o == ST_TON) && state_o == ST_SS
    |-> ton_cnt_r inside {[TON_MIN_US * US_CYC - 4 : TON_MAX_US * US_CYC + 4]})
    else $error("turn-on delay out of range");
  chk_ton_entry: assert property ($rose(state_o == ST_TON)
    |-> $past(state_o) inside {ST_IDLE, ST_HICCUP})
    else $error("turn-on delay entered from wrong state");
  chk_ss_no_fault: assert property (state_o == ST_SS
    |=> !(state_o inside {ST_HICCUP, ST_LATCH})) else $error("fault response in soft-start");
  chk_stop_switches: assert property ((state_o == ST_STOP)[*3] |-> !stage_tristate_o)
    else $error("stage tri-stated during soft-stop");
  chk_stop_tristate: assert property (state_o == ST_STOP ##1 state_o == ST_IDLE
    |-> ##[0:2] stage_tristate_o) else $error("stage not tri-stated after soft-stop");
  chk_abort_path: assert property ($rose(state_o == ST_TOFF)
    |-> $past(state_o) inside {ST_TON, ST_SS, ST_RUN}) else $error("turn-off from wrong state");
  cover property ($rose(state_o == ST_SS));
  cover property (state_o == ST_STOP ##1 state_o == ST_IDLE);
  cover property (!init_done_o && bus_rd_i);
endmodule
bind buck_sequencer buck_sequencer_checker u_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_ready_o(bus_ready_o), .stage_tristate_o(stage_tristate_o), .init_done_o(init_done_o),
  .state_o(state_o));

/* File: sim/buck_sequencer_test.sv */
// self-checking bench for the start/stop sequencer
// assumes the host model drives the command port and enable pin
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module buck_sequencer_test
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, reset_n_i, supply, valley, uv, ref_fb, wr, rd, hi, en, ready, hs, ls, tri_o;
  logic [7:0] addr, wdata, rdata, q;
  logic [3:0] state;
  logic       lsv, cont, idone;
  logic [9:0] lsc, vref;
  logic [1:0] fsel;
  logic       rdy;
  int         fails, checks_done, n, i;
  logic [7:0] ra [8] = '{8'h01, 8'h02, 8'h60, 8'h60, 8'h61, 8'h64, 8'h65, 8'h99};
  logic [7:0] re [8] = '{RUN_RST, ONOFF_RST, TON_RST[7:0], TON_RST[15:8], SS_RST[7:0],
                         TOFF_RST[7:0], STOP_RST[7:0], 8'h00};
  buck_sequencer u_dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .core_supply_good_i(supply),
    .enable_pin_i(en), .valley_over_limit_i(valley), .undervoltage_cmp_i(uv),
    .ref_above_fb_i(ref_fb), .ls_current_valid_i(lsv), .ls_current_i(lsc),
    .second_mode_select_strap_i(1'b0), .strap_freq_i(2'b00), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_hi_byte_i(hi), .bus_rdata_o(rdata),
    .bus_ready_o(ready), .hs_enable_o(hs), .ls_enable_o(ls), .stage_tristate_o(tri_o),
    .continuous_mode_o(cont), .freq_sel_o(fsel), .vref_code_o(vref), .init_done_o(idone),
    .state_o(state));
  pmbus_host_model u_host (
    .clk_i(clk_sys_i), .rdata_i(rdata), .ready_i(ready), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata), .hi_o(hi), .en_o(en));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wait_st(input logic [3:0] s, input int lim);
    n = 0;
    while (state !== s && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    fails++;
    tally_and_finish();
  end
  initial begin
    reset_n_i = 1'b0;
    supply = 1'b1;
    valley = 1'b0;
    uv = 1'b0;
    ref_fb = 1'b0;
    lsv = 1'b1;
    lsc = 10'h123;
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    u_host.xfer(1'b0, 8'h60, 1'b0, 8'h00, rdy, q);
    `CHK(rdy, 1'b0)
    `CHK(idone, 1'b0)
    wait_st(ST_IDLE, 25000);
    `CHK(n inside {[19990:20020]}, 1'b1)
    `CHK(idone, 1'b1)
    for (i = 0; i < 8; i++) begin
      u_host.xfer(1'b0, ra[i], i == 3, 8'h00, rdy, q);
      `CHK(rdy, 1'b1)
      `CHK(q, re[i])
    end
    for (i = 0; i < 3; i++) begin
      u_host.xfer(1'b1, ra[i + 3], 1'b0, (i == 0) ? 8'h10 : 8'h00, rdy, q);
      u_host.xfer(1'b0, ra[i + 3], 1'b0, 8'h00, rdy, q);
      `CHK(q, (i == 0) ? 8'h10 : 8'h00)
    end
    `CHK({cont, fsel}, 3'b000)
    u_host.xfer(1'b1, ADDR_USERCFG, 1'b0, 8'h01, rdy, q);
    u_host.xfer(1'b1, ADDR_FREQ, 1'b0, 8'h82, rdy, q);
    tick(2);
    `CHK(cont, 1'b1)
    `CHK(fsel, 2'b10)
    u_host.drive_en(1'b1);
    u_host.drive_en(1'b0);
    tick(30);
    `CHK(state, ST_IDLE)
    u_host.drive_en(1'b1);
    tick(15);
    u_host.drive_en(1'b0);
    tick(40);
    `CHK(state, ST_IDLE)
    u_host.drive_en(1'b1);
    wait_st(ST_TON, 100);
    `CHK(state, ST_TON)
    wait_st(ST_SS, 6000);
    `CHK(n inside {[4990:5010]}, 1'b1)
    tick(50);
    `CHK(hs, 1'b0)
    `CHK(ls, 1'b0)
    @(posedge clk_sys_i);
    ref_fb <= 1'b1;
    uv <= 1'b1;
    tick(50);
    `CHK(hs, 1'b1)
    `CHK(ls, 1'b1)
    @(posedge clk_sys_i);
    valley <= 1'b1;
    tick(10);
    `CHK(ls, 1'b1)
    `CHK(hs, 1'b0)
    @(posedge clk_sys_i);
    valley <= 1'b0;
    u_host.xfer(1'b0, ADDR_CUR_STAT, 1'b0, 8'h00, rdy, q);
    `CHK(q[VALLEY_FLAG_BIT], 1'b1)
    u_host.xfer(1'b1, ADDR_CUR_STAT, 1'b0, 8'h40, rdy, q);
    u_host.xfer(1'b0, ADDR_CUR_STAT, 1'b0, 8'h00, rdy, q);
    `CHK(q[VALLEY_FLAG_BIT], 1'b0)
    tick(60000);
    `CHK(state, ST_SS)
    `CHK(vref inside {[10'h070:10'h080]}, 1'b1)
    @(posedge clk_sys_i);
    uv <= 1'b0;
    u_host.drive_en(1'b0);
    wait_st(ST_TOFF, 100);
    `CHK(state, ST_TOFF)
    wait_st(ST_STOP, 200);
    tick(100);
    `CHK(state, ST_STOP)
    `CHK(tri_o, 1'b0)
    wait_st(ST_IDLE, 20000);
    tick(3);
    `CHK(tri_o, 1'b1)
    `CHK(hs, 1'b0)
    `CHK(vref, 10'h000)
    u_host.xfer(1'b0, ADDR_CUR_TEL, 1'b0, 8'h00, rdy, q);
    `CHK(q, 8'h23)
    u_host.xfer(1'b0, ADDR_CUR_TEL, 1'b1, 8'h00, rdy, q);
    `CHK(q, 8'h01)
    tally_and_finish();
  end
endmodule
